// ---- hdl/supply_protect_pkg.sv ----
package supply_protect_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] VIN_WINDOW_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] OVERCURRENT_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] SENSE_GAIN_CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] FLAG_STATUS_OFFSET = 8'h0c;

  // Input voltage window control fields
  localparam int UNDER_LOCK_ENABLE_BIT = 7;
  localparam int UNDER_LOCK_STATUS_BIT = 6;
  localparam int UNDER_LOCK_RISE_IRQ_EN_BIT = 5;
  localparam int UNDER_LOCK_FALL_IRQ_EN_BIT = 4;
  localparam int OVER_LOCK_ENABLE_BIT = 3;
  localparam int OVER_LOCK_STATUS_BIT = 2;
  localparam int OVER_LOCK_RISE_IRQ_EN_BIT = 1;
  localparam int OVER_LOCK_FALL_IRQ_EN_BIT = 0;
  localparam logic [7:0] VIN_WRITE_MASK = 8'hbb;

  // Overcurrent control fields
  localparam int OVERCURRENT_ENABLE_BIT = 7;
  localparam int BLANKING_SELECT_MSB = 6;
  localparam int BLANKING_SELECT_LSB = 5;
  localparam int THRESHOLD_MSB = 4;
  localparam logic [4:0] THRESHOLD_TOP_CODE = 5'h1e;

  // Sense gain field
  localparam int SENSE_GAIN_MSB = 4;

  // Flag status fields, write one to clear
  localparam int UNDER_LOCK_FLAG_BIT = 0;
  localparam int OVER_LOCK_FLAG_BIT = 1;
  localparam int OVERCURRENT_FLAG_BIT = 2;

  // Values after reset
  localparam logic [7:0] VIN_WINDOW_RESET = 8'h00;
  localparam logic [7:0] OVERCURRENT_RESET = 8'h00;
  localparam logic [4:0] SENSE_GAIN_RESET = 5'h00;

  // Clock and blanking times
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int BLANK_0_NS = 110;
  localparam int BLANK_1_NS = 200;
  localparam int BLANK_2_NS = 380;
  localparam int BLANK_3_NS = 740;
  localparam logic [4:0] BLANK_0_CYCLES = 5'((BLANK_0_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [4:0] BLANK_1_CYCLES = 5'((BLANK_1_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [4:0] BLANK_2_CYCLES = 5'((BLANK_2_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [4:0] BLANK_3_CYCLES = 5'((BLANK_3_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // Comparator outputs from the analog side
  typedef struct packed {
    logic under_cmp;
    logic over_cmp;
    logic overcurrent_cmp;
  } comparator_type;

  // Gate drive enables
  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } drive_type;

endpackage

// ---- hdl/supply_fault_protect_ctrl.sv ----
// What this block does
// - Bit 7 of the window register enables undervoltage lockout logic.
// - Bit 6 reads undervoltage status, read only.
// - Bit 5 lets a rising undervoltage edge set the undervoltage flag.
// - Bit 4 lets a falling undervoltage edge set the undervoltage flag.
// - Bit 3 enables overvoltage lockout logic.
// - Bit 2 reads overvoltage status, read only.
// - Bit 1 lets a rising overvoltage edge set the overvoltage flag.
// - Bit 0 lets a falling overvoltage edge set the overvoltage flag.
// - Overcurrent sets its flag and ends the high-side pulse at once.
// - High side restarts next switching cycle; trips again if overcurrent persists.
// - Software clears overcurrent flag only after one clean switching cycle.
// - Overcurrent flag sets regardless of any interrupt enable.
// - Blanking after high-side turn-on: 110, 200, 380 or 740 ns.
// - Overcurrent control bit 7 enables the comparator; otherwise ignored.
// - Five-bit threshold code; codes 11110 and 11111 both give the top level.
// - Overcurrent is judged only while the high side conducts.
// - Five-bit sense gain drives the sense path; bits 7 to 5 read zero.
// - Enabled undervoltage lockout forces both drives off.
// - Enabled overvoltage lockout forces both drives off.
// - Voltage flags set whether or not lockout is enabled.
//
// Local design decisions: the placing of the registers and the APB slave port.
module supply_fault_protect_ctrl
  import supply_protect_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire comparator_type cmp_raw,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic cycle_start,
  output drive_type drive,
  output logic under_lock_enable,
  output logic over_lock_enable,
  output logic overcurrent_enable,
  output logic [4:0] overcurrent_threshold,
  output logic [4:0] sense_gain_code
);

  // Blanking select to cycle count
  function automatic logic [4:0] blank_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: blank_cycles = BLANK_0_CYCLES;
      2'h1: blank_cycles = BLANK_1_CYCLES;
      2'h2: blank_cycles = BLANK_2_CYCLES;
      2'h3: blank_cycles = BLANK_3_CYCLES;
    endcase
  endfunction

  // Threshold code with the top two codes folded together
  function automatic logic [4:0] clip_threshold(input logic [4:0] code);
    clip_threshold = (code > THRESHOLD_TOP_CODE) ? THRESHOLD_TOP_CODE : code;
  endfunction

  comparator_type sync1_reg;
  comparator_type sync2_reg;
  comparator_type prev_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [7:0] vin_reg;
  logic [7:0] vin_next;
  logic [7:0] occtl_reg;
  logic [7:0] occtl_next;
  logic [4:0] gain_reg;
  logic [4:0] gain_next;
  logic under_flag_reg;
  logic under_flag_next;
  logic over_flag_reg;
  logic over_flag_next;
  logic oc_flag_reg;
  logic oc_flag_next;
  logic oc_term_reg;
  logic oc_term_next;
  logic oc_seen_reg;
  logic oc_seen_next;
  logic clean_reg;
  logic clean_next;
  logic [4:0] blank_reg;
  logic [4:0] blank_next;
  drive_type drive_reg;
  drive_type drive_next;
  logic [4:0] thr_reg;
  logic [4:0] thr_next;
  logic wr_en;
  logic [7:0] wbyte;
  logic under_rise;
  logic under_fall;
  logic over_rise;
  logic over_fall;
  logic under_lockout;
  logic over_lockout;
  logic oc_trip;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Edges seen from the second stage only, one pulse per edge
  assign under_rise = sync2_reg.under_cmp & ~prev_reg.under_cmp;
  assign under_fall = ~sync2_reg.under_cmp & prev_reg.under_cmp;
  assign over_rise = sync2_reg.over_cmp & ~prev_reg.over_cmp;
  assign over_fall = ~sync2_reg.over_cmp & prev_reg.over_cmp;

  // A write lands at the access edge; zero wait states
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign wbyte = pwdata[7:0];

  // APB answer: ready rises for the access phase, read data captured at setup
  always_comb
  begin
    pready_next = psel & ~penable;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel & ~penable)
    begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        VIN_WINDOW_CONTROL_OFFSET:
        begin
          prdata_next[7:0] = vin_reg;
          prdata_next[UNDER_LOCK_STATUS_BIT] = sync2_reg.under_cmp;
          prdata_next[OVER_LOCK_STATUS_BIT] = sync2_reg.over_cmp;
        end
        OVERCURRENT_CONTROL_OFFSET: prdata_next[7:0] = occtl_reg;
        SENSE_GAIN_CONTROL_OFFSET: prdata_next[SENSE_GAIN_MSB:0] = gain_reg;
        FLAG_STATUS_OFFSET:
        begin
          prdata_next[UNDER_LOCK_FLAG_BIT] = under_flag_reg;
          prdata_next[OVER_LOCK_FLAG_BIT] = over_flag_reg;
          prdata_next[OVERCURRENT_FLAG_BIT] = oc_flag_reg;
        end
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Control registers; status bits are never stored, so writes cannot touch them
  always_comb
  begin
    vin_next = vin_reg;
    occtl_next = occtl_reg;
    gain_next = gain_reg;
    if (wr_en && paddr == VIN_WINDOW_CONTROL_OFFSET)
    begin
      vin_next = wbyte & VIN_WRITE_MASK;
    end
    if (wr_en && paddr == OVERCURRENT_CONTROL_OFFSET)
    begin
      occtl_next = wbyte;
    end
    if (wr_en && paddr == SENSE_GAIN_CONTROL_OFFSET)
    begin
      gain_next = wbyte[SENSE_GAIN_MSB:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vin_reg <= VIN_WINDOW_RESET;
      occtl_reg <= OVERCURRENT_RESET;
      gain_reg <= SENSE_GAIN_RESET;
    end
    else
    begin
      vin_reg <= vin_next;
      occtl_reg <= occtl_next;
      gain_reg <= gain_next;
    end
  end

  // undervoltage lockout gated by its enable
  assign under_lockout = vin_reg[UNDER_LOCK_ENABLE_BIT] & sync2_reg.under_cmp;
  // overvoltage lockout gated by its enable
  assign over_lockout = vin_reg[OVER_LOCK_ENABLE_BIT] & sync2_reg.over_cmp;

  // trip only when enabled, conducting and past blanking
  assign oc_trip = occtl_reg[OVERCURRENT_ENABLE_BIT] & drive_reg.high_side_drive
    & (blank_reg == 5'h00) & sync2_reg.overcurrent_cmp;

  // Flags: a set in the same cycle as a clear wins, so no event is lost
  always_comb
  begin
    under_flag_next = under_flag_reg;
    over_flag_next = over_flag_reg;
    oc_flag_next = oc_flag_reg;
    if (wr_en && paddr == FLAG_STATUS_OFFSET)
    begin
      if (wbyte[UNDER_LOCK_FLAG_BIT])
      begin
        under_flag_next = 1'b0;
      end
      if (wbyte[OVER_LOCK_FLAG_BIT])
      begin
        over_flag_next = 1'b0;
      end
      // clear accepted after a clean cycle
      if (wbyte[OVERCURRENT_FLAG_BIT] && clean_reg)
      begin
        oc_flag_next = 1'b0;
      end
    end
    // Sets come after the clears so an event in the clear cycle survives
    // edge flags ignore lockout enables
    if (under_rise && vin_reg[UNDER_LOCK_RISE_IRQ_EN_BIT])
    begin
      under_flag_next = 1'b1;
    end
    if (under_fall && vin_reg[UNDER_LOCK_FALL_IRQ_EN_BIT])
    begin
      under_flag_next = 1'b1;
    end
    if (over_rise && vin_reg[OVER_LOCK_RISE_IRQ_EN_BIT])
    begin
      over_flag_next = 1'b1;
    end
    if (over_fall && vin_reg[OVER_LOCK_FALL_IRQ_EN_BIT])
    begin
      over_flag_next = 1'b1;
    end
    if (oc_trip)
    begin
      oc_flag_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      under_flag_reg <= 1'b0;
      over_flag_reg <= 1'b0;
      oc_flag_reg <= 1'b0;
    end
    else
    begin
      under_flag_reg <= under_flag_next;
      over_flag_reg <= over_flag_next;
      oc_flag_reg <= oc_flag_next;
    end
  end

  // Cycle-by-cycle limit, clean-cycle tracking, blanking and gate drive
  always_comb
  begin
    oc_term_next = oc_term_reg;
    oc_seen_next = oc_seen_reg;
    clean_next = clean_reg;
    // release at the next cycle start
    if (cycle_start)
    begin
      oc_term_next = 1'b0;
      oc_seen_next = 1'b0;
      clean_next = ~oc_seen_reg;
    end
    // A trip restarts the clean run, so a whole untouched cycle must follow
    // terminate the pulse now; a trip outranks a cycle boundary
    if (oc_trip)
    begin
      oc_term_next = 1'b1;
      oc_seen_next = 1'b1;
      clean_next = 1'b0;
    end
    drive_next.high_side_drive = pwm_high_req & ~oc_term_next & ~under_lockout & ~over_lockout;
    drive_next.low_side_drive = pwm_low_req & ~under_lockout & ~over_lockout;
    // load blanking count on high-side turn-on
    // The count idles at zero; it only matters while the high side is on
    if (drive_next.high_side_drive && !drive_reg.high_side_drive)
    begin
      blank_next = blank_cycles(occtl_reg[BLANKING_SELECT_MSB:BLANKING_SELECT_LSB]);
    end
    else if (blank_reg != 5'h00)
    begin
      blank_next = blank_reg - 5'h01;
    end
    else
    begin
      blank_next = blank_reg;
    end
    // fold the top two threshold codes
    thr_next = clip_threshold(occtl_reg[THRESHOLD_MSB:0]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_term_reg <= 1'b0;
      oc_seen_reg <= 1'b0;
      clean_reg <= 1'b0;
      blank_reg <= 5'h00;
      drive_reg <= '0;
      thr_reg <= 5'h00;
    end
    else
    begin
      oc_term_reg <= oc_term_next;
      oc_seen_reg <= oc_seen_next;
      clean_reg <= clean_next;
      blank_reg <= blank_next;
      drive_reg <= drive_next;
      thr_reg <= thr_next;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign drive = drive_reg;
  assign under_lock_enable = vin_reg[UNDER_LOCK_ENABLE_BIT];
  assign over_lock_enable = vin_reg[OVER_LOCK_ENABLE_BIT];
  assign overcurrent_enable = occtl_reg[OVERCURRENT_ENABLE_BIT];
  assign overcurrent_threshold = thr_reg;
  // gain code to the sense path
  assign sense_gain_code = gain_reg;

endmodule // supply_fault_protect_ctrl

// ---- test/supply_fault_protect_ctrl_properties.sv ----
module protect_checker
  import supply_protect_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire comparator_type cmp_raw,
  input wire logic pwm_high_req,
  input wire drive_type drive,
  input wire logic under_lock_enable,
  input wire logic over_lock_enable,
  input wire logic overcurrent_enable,
  input wire logic [4:0] overcurrent_threshold,
  input wire logic [4:0] sense_gain_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_done;
  logic no_lock;
  // Completed write, and no lockout that could cut the drives
  assign wr_done = psel && penable && pwrite && pready;
  assign no_lock = !under_lock_enable && !over_lock_enable;
  AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready too long");
  AST_UNDER_LOCK: assert property ((under_lock_enable && cmp_raw.under_cmp) [*4]
    |-> drive == 2'b00) else $error("drive on in under lockout");
  AST_OVER_LOCK: assert property ((over_lock_enable && cmp_raw.over_cmp) [*4]
    |-> drive == 2'b00) else $error("drive on in over lockout");
  AST_TRIP_NEEDS_EN: assert property ($fell(drive.high_side_drive) && no_lock
    && $past(pwm_high_req) && $past(pwm_high_req, 2) |-> $past(overcurrent_enable))
    else $error("high side cut while disabled");
  AST_BLANK_MIN: assert property ($rose(drive.high_side_drive) && no_lock
    ##1 (pwm_high_req && no_lock) [*3] |-> drive.high_side_drive)
    else $error("high side cut inside blanking");
  AST_THRESH_FOLD: assert property (overcurrent_threshold != 5'h1f)
    else $error("threshold top code not folded");
  AST_GAIN_WRITE: assert property ($changed(sense_gain_code)
    |-> $past(wr_done && paddr == SENSE_GAIN_CONTROL_OFFSET)) else $error("gain moved");
  AST_UNDER_EN_WRITE: assert property ($changed(under_lock_enable)
    |-> $past(wr_done && paddr == VIN_WINDOW_CONTROL_OFFSET)) else $error("enable moved");
endmodule // protect_checker

bind supply_fault_protect_ctrl protect_checker i_protect_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready, .cmp_raw, .pwm_high_req, .drive, .under_lock_enable,
  .over_lock_enable, .overcurrent_enable, .overcurrent_threshold, .sense_gain_code);

// ---- test/supply_analog_model.sv ----
module supply_analog_model
  import supply_protect_pkg::*;
#(
  parameter int PERIOD = 40,
  parameter int HIGH_LEN = 24
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic under_lvl,
  input wire logic over_lvl,
  input wire logic oc_lvl,
  input wire drive_type drive,
  output comparator_type cmp_raw,
  output logic pwm_high_req,
  output logic pwm_low_req,
  output logic cycle_start
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase;
  // Switching period counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      phase <= 0;
    else
      phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
  // Dead time of two clocks keeps both switches from conducting together
  assign cycle_start = presetn && phase == 0;
  assign pwm_high_req = phase >= 1 && phase <= HIGH_LEN;
  assign pwm_low_req = phase >= HIGH_LEN + 3 && phase < PERIOD - 1;
  assign cmp_raw = {under_lvl, over_lvl, oc_lvl && drive.high_side_drive};
endmodule // supply_analog_model

// ---- test/tb_top.sv ----
module tb_top
  import supply_protect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PERIOD = 40;
  localparam int HIGH_LEN = 24;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata, r0, r1, r2;
  logic pready, pslverr, rerr, pwm_high_req, pwm_low_req, cycle_start;
  logic under_lock_enable, over_lock_enable, overcurrent_enable;
  logic [4:0] overcurrent_threshold, sense_gain_code;
  logic under_lvl = 0, over_lvl = 0, oc_lvl = 0;
  logic [1:0] seen;
  comparator_type cmp_raw;
  drive_type drive;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  always #25 pclk = ~pclk;
  supply_fault_protect_ctrl i_supply_fault_protect_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_raw, .pwm_high_req,
    .pwm_low_req, .cycle_start, .drive, .under_lock_enable, .over_lock_enable,
    .overcurrent_enable, .overcurrent_threshold, .sense_gain_code);
  supply_analog_model #(.PERIOD(PERIOD), .HIGH_LEN(HIGH_LEN)) i_supply_analog_model (.pclk,
    .presetn, .under_lvl, .over_lvl, .oc_lvl, .drive, .cmp_raw, .pwm_high_req, .pwm_low_req,
    .cycle_start);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, $urandom);
    chk($sformatf("read %h", a), exp, rdata);
  endtask
  task automatic set_lvl(input int s, input logic v);
    @(posedge pclk);
    if (s == 0)
      under_lvl <= v;
    else
      over_lvl <= v;
  endtask
  // Length of the next whole high-side pulse
  task automatic pulse_len(output int len);
    len = 0;
    // Leave the edge's time step so a drive launched there is already seen
    @(negedge pclk);
    for (int w = 0; w < 99 && drive.high_side_drive === 1'b1; w++) @(negedge pclk);
    for (int w = 0; w < 99 && drive.high_side_drive !== 1'b1; w++) @(negedge pclk);
    while (drive.high_side_drive === 1'b1 && len < 99)
    begin
      @(negedge pclk);
      len++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h539d));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 5; a++) rd(8'(a * 4), 32'h0);
    chk("unmapped error", 1, rerr);
    repeat (4)
    begin
      r0 = $urandom;
      r1 = $urandom & 32'h7e;
      r2 = $urandom;
      apb(1'b1, 8'h00, r0);
      apb(1'b1, 8'h04, r1);
      apb(1'b1, 8'h08, r2);
      apb(1'b1, 8'h10, $urandom);
      rd(8'h00, r0 & 32'hbb);
      rd(8'h04, r1);
      rd(8'h08, r2 & 32'h1f);
      chk("gain port", r2[4:0], sense_gain_code);
      chk("enable ports", {r0[7], r0[3]}, {under_lock_enable, over_lock_enable});
    end
    apb(1'b1, 8'h04, 32'h1f);
    // The folded code is registered one edge after the write lands
    repeat (2) @(negedge pclk);
    chk("threshold port", 5'h1e, overcurrent_threshold);
    $display("register test done");
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 4; m++)
      begin
        apb(1'b1, 8'h00, s ? m : m << 4);
        set_lvl(s, 1'b1);
        repeat (6) @(posedge pclk);
        rd(8'h00, (s ? m + 4 : (m << 4) + 64));
        rd(8'h0c, 32'(m[1]) << s);
        set_lvl(s, 1'b0);
        repeat (6) @(posedge pclk);
        rd(8'h0c, 32'(m[1] | m[0]) << s);
        apb(1'b1, 8'h0c, 32'h3);
        rd(8'h0c, 32'h0);
      end
    $display("edge flag test done");
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, 8'h00, s ? 32'h08 : 32'h80);
      set_lvl(s, 1'b1);
      repeat (6) @(negedge pclk);
      seen = 2'b00;
      repeat (PERIOD) @(negedge pclk) seen |= drive;
      chk("locked drives", 0, seen);
      set_lvl(s, 1'b0);
      repeat (PERIOD) @(negedge pclk) seen |= drive;
      chk("released drives", 3, seen);
    end
    apb(1'b1, 8'h00, 32'h0);
    $display("lockout test done");
    oc_lvl <= 1'b1;
    for (int i = 4; i >= 0; i--)
    begin
      apb(1'b1, 8'h04, (i < 4 ? 32'h80 : 32'h0) | (i[1:0] << 5) | ($urandom & 32'h0f));
      repeat (2)
      begin
        pulse_len(n);
        chk("pulse", i < 4 ? ((i == 0 ? BLANK_0_NS : i == 1 ? BLANK_1_NS : i == 2 ? BLANK_2_NS
          : BLANK_3_NS) + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS + 1 : HIGH_LEN, n);
      end
      chk("oc enable port", i < 4, overcurrent_enable);
      rd(8'h0c, i < 4 ? 32'h4 : 32'h0);
    end
    apb(1'b1, 8'h0c, 32'h4);
    rd(8'h0c, 32'h4);
    oc_lvl <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h4);
    rd(8'h0c, 32'h4);
    repeat (2 * PERIOD) @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h4);
    rd(8'h0c, 32'h0);
    $display("overcurrent test done");
    conclude();
  end
  // Watchdog well beyond the thousand-odd cycles the tests need
  initial
  begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    conclude();
  end
endmodule // tb_top
